/* core/srp_device.sv */
// device end: serial register port, power monitor, fine error count
// assumes the link pins and sense inputs are asynchronous to core_clk
`include "srp_map.svh"
module srp_device #(
  parameter int unsigned RST_DLY_CYC = `SRP_RST_DLY_CYC,
  parameter int unsigned BRAKE_DELAY_CAPACITOR_CYC = `SRP_BRAKE_DELAY_CAPACITOR_CYC
) (
  input wire logic core_clk,
  input wire logic rst_b,
  srp_link_if.dev link,
  input wire logic supply_sense_a,
  input wire logic supply_sense_b,
  input wire logic rot_pulse,
  output logic [6:0][11:0] cfg_words,
  output logic por_n,
  output logic drv_en,
  output logic park_en,
  output logic brake_en
);
  srp_pkg::srp_dev_s st_reg; // registered state
  srp_pkg::srp_dev_s st_next; // next state

  // synchronised pins
  logic sel_n_s;
  logic rw_s;
  logic sclk_s;
  logic sdio_s;
  logic sense_a_s;
  logic sense_b_s;
  logic rot_s;
  logic [6:0] pins_s;

  // decoded events; the three edges last one core cycle each, under_v is a level
  logic under_v;
  logic sclk_rise;
  logic rw_rise;
  logic rot_rise;
  logic [11:0] data_new; // data word including the bit now arriving

  // select and sense lines idle high so reset does not look active
  srp_sync #(
    .W(7),
    .RST_VAL(7'h31)
  ) u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .async_in({rot_pulse, supply_sense_b, supply_sense_a,
               link.sdio, link.serial_clk, link.rd_wr,
               link.port_select_n}),
    .sync_out(pins_s)
  );

  // split the synchronised group
  assign sel_n_s = pins_s[0];
  assign rw_s = pins_s[1];
  assign sclk_s = pins_s[2];
  assign sdio_s = pins_s[3];
  assign sense_a_s = pins_s[4];
  assign sense_b_s = pins_s[5];
  assign rot_s = pins_s[6];

  // edge finders look only at second-stage values
  assign sclk_rise = sclk_s & ~st_reg.sclk_d;
  assign rw_rise = rw_s & ~st_reg.rw_d;
  assign rot_rise = rot_s & ~st_reg.rot_d;
  // sense inputs are comparator outputs: high means above reference
  assign under_v = ~sense_a_s | ~sense_b_s;
  // lsb arrives first, so each new bit enters at the top
  assign data_new = {sdio_s, st_reg.data_in[11:1]};

  // next-state logic for power, frame and speed error
  always_comb begin
    st_next = st_reg;
    st_next.sclk_d = sclk_s;
    st_next.rw_d = rw_s;
    st_next.rot_d = rot_s;

    // power monitor
    unique case (st_reg.pwr)
      srp_pkg::PWR_RESET: begin
        st_next.por_n = 1'b0;
        st_next.drv_en = 1'b0;
        st_next.park_en = 1'b0;
        st_next.brake_en = 1'b0;
        if (under_v) begin
          // supply not good yet: delay restarts
          st_next.dly_cnt = 16'h0000;
        end else if (st_reg.dly_cnt == 16'(RST_DLY_CYC - 1)) begin
          st_next.pwr = srp_pkg::PWR_RUN;
          st_next.por_n = 1'b1;
          st_next.drv_en = 1'b1;
          st_next.dly_cnt = 16'h0000;
        end else begin
          st_next.dly_cnt = st_reg.dly_cnt + 16'h0001;
        end
      end
      srp_pkg::PWR_RUN: begin
        if (under_v) begin
          // reset and parking in the same cycle, then brake delay
          st_next.pwr = srp_pkg::PWR_PARK;
          st_next.por_n = 1'b0;
          st_next.drv_en = 1'b0;
          st_next.park_en = 1'b1;
          st_next.dly_cnt = 16'h0000;
        end
      end
      srp_pkg::PWR_PARK: begin
        if (!under_v) begin
          // supply came back: start a fresh reset delay
          st_next.pwr = srp_pkg::PWR_RESET;
          st_next.park_en = 1'b0;
          st_next.dly_cnt = 16'h0000;
        end else if (st_reg.dly_cnt == 16'(BRAKE_DELAY_CAPACITOR_CYC - 1)) begin
          st_next.pwr = srp_pkg::PWR_BRAKE;
          st_next.brake_en = 1'b1;
        end else begin
          st_next.dly_cnt = st_reg.dly_cnt + 16'h0001;
        end
      end
      srp_pkg::PWR_BRAKE: begin
        // low sides stay on until the supply is good again
        if (!under_v) begin
          st_next.pwr = srp_pkg::PWR_RESET;
          st_next.park_en = 1'b0;
          st_next.brake_en = 1'b0;
          st_next.dly_cnt = 16'h0000;
        end
      end
    endcase

    if (st_next.pwr != srp_pkg::PWR_RUN) begin
      // held in reset: defaults everywhere, pin floating
      for (int i = 0; i < `SRP_NUM_WREGS; i++) begin
        st_next.regs[i] = `SRP_REG_RESET;
      end
      st_next.fine_err = `SRP_REG_RESET;
      st_next.period = 12'h000;
      st_next.shift = 12'h000;
      st_next.bit_cnt = 5'h00;
      st_next.addr = 4'h0;
      st_next.data_in = 12'h000;
      st_next.sdio_oe = 1'b0;
    end else begin
      // measured rotation time in core clocks, saturating
      if (st_reg.period != 12'hFFF) begin
        st_next.period = st_reg.period + 12'h001;
      end
      if (rot_rise) begin
        // wraps as a twelve-bit difference
        st_next.fine_err = st_reg.regs[`SRP_FINE_CNT_IDX]
                           - st_reg.period;
        // the mark's own cycle is the first of the next period
        st_next.period = 12'h001;
      end

      if (sel_n_s) begin
        // deselected: partial frame dropped, registers untouched
        st_next.bit_cnt = 5'h00;
        st_next.addr = 4'h0;
        st_next.data_in = 12'h000;
        st_next.sdio_oe = 1'b0;
      end else begin
        // rw low: listen only; rw high: drive the shift lsb
        st_next.sdio_oe = rw_s;
        if (rw_rise && st_reg.bit_cnt >= `SRP_ADDR_BITS &&
            st_reg.addr == `SRP_FINE_ERR_ADDR) begin
          // only the error count is readable; others keep shift
          st_next.shift = st_reg.fine_err;
        end
        if (sclk_rise) begin
          // count saturates so a long frame cannot write twice
          if (st_reg.bit_cnt != `SRP_FRAME_BITS) begin
            st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
          end
          if (!rw_s) begin
            if (st_reg.bit_cnt < `SRP_ADDR_BITS) begin
              // first four bits only make the address
              st_next.addr = {sdio_s, st_reg.addr[3:1]};
            end else if (st_reg.bit_cnt < `SRP_FRAME_BITS) begin
              st_next.data_in = data_new;
              // complete frame: load, keep a copy for read back
              if (st_reg.bit_cnt == `SRP_LAST_BIT &&
                  st_reg.addr < `SRP_FINE_ERR_ADDR) begin
                st_next.regs[st_reg.addr[2:0]] = data_new;
                st_next.shift = data_new;
              end
            end
          end else begin
            // lsb first, zeros fill behind it
            st_next.shift = {1'b0, st_reg.shift[11:1]};
          end
        end
      end
    end
    st_next.sdio_out = st_next.shift[0];
  end

  // single state register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // every output straight from the state register
  assign link.dev_sdio_out = st_reg.sdio_out;
  assign link.dev_sdio_oe = st_reg.sdio_oe;
  assign cfg_words = st_reg.regs;
  assign por_n = st_reg.por_n;
  assign drv_en = st_reg.drv_en;
  assign park_en = st_reg.park_en;
  assign brake_en = st_reg.brake_en;
endmodule

/* core/srp_host.sv */
// host end: runs one serial frame per command from a plain port
// assumes the device answers within half a serial clock period
`include "srp_map.svh"
module srp_host (
  input wire logic core_clk,
  input wire logic rst_b,
  srp_link_if.host link,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata
);
  srp_pkg::srp_host_s st_reg; // registered state
  srp_pkg::srp_host_s st_next; // next state
  logic sdio_s; // data line after two flops
  logic half_done; // half serial period elapsed
  logic [4:0] last_idx; // last bit of current phase
  logic start; // accepted command write

  srp_sync #(
    .W(1),
    .RST_VAL(1'b1)
  ) u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .async_in(link.sdio),
    .sync_out(sdio_s)
  );

  assign half_done = st_reg.tmr == 3'(`SRP_HALF_CYC - 1);
  // reads send four address bits, then take twelve data bits;
  // read-back has no address part, so it runs all sixteen clocks
  assign last_idx = !st_reg.is_read ? `SRP_LAST_BIT :
                    (st_reg.rx ? 5'h0B : 5'h03);
  // commands while busy are dropped
  assign start = bus_wr && bus_addr == `SRP_H_CMD &&
                 st_reg.ph == srp_pkg::HP_IDLE;

  // frame engine and command port
  always_comb begin
    st_next = st_reg;
    st_next.tmr = half_done ? 3'h0 : st_reg.tmr + 3'h1;
    st_next.bus_rdata = 32'h00000000;

    unique case (st_reg.ph)
      srp_pkg::HP_IDLE: begin
        st_next.tmr = 3'h0;
        if (start) begin
          // bits 3:0 address, 15:4 data, sent lsb first
          st_next.frame = bus_wdata[15:0];
          st_next.rx = bus_wdata[`SRP_CMD_RBACK];
          st_next.is_read = bus_wdata[`SRP_CMD_READ];
          st_next.rw = bus_wdata[`SRP_CMD_RBACK];
          st_next.sel_n = 1'b0;
          st_next.sd_out = bus_wdata[0];
          st_next.sd_oe = ~bus_wdata[`SRP_CMD_RBACK];
          st_next.bit_idx = 5'h00;
          st_next.rdata = 12'h000;
          st_next.ph = srp_pkg::HP_SETUP;
        end
      end
      srp_pkg::HP_SETUP: begin
        // select and first bit settle before any clock
        if (half_done) begin
          st_next.ph = srp_pkg::HP_LOW;
        end
      end
      srp_pkg::HP_LOW: begin
        if (half_done) begin
          if (st_reg.rx && st_reg.bit_idx < 5'h0C) begin
            // sampled just before the edge that shifts it away;
            // the padding clocks of a read-back carry only zeros
            st_next.rdata = {sdio_s, st_reg.rdata[11:1]};
          end
          st_next.sclk = 1'b1;
          st_next.ph = srp_pkg::HP_HIGH;
        end
      end
      srp_pkg::HP_HIGH: begin
        if (half_done) begin
          st_next.sclk = 1'b0;
          if (st_reg.bit_idx != last_idx) begin
            st_next.bit_idx = st_reg.bit_idx + 5'h01;
            st_next.sd_out = st_reg.frame[4'(st_reg.bit_idx + 5'h01)];
            st_next.ph = srp_pkg::HP_LOW;
          end else if (st_reg.is_read && !st_reg.rx) begin
            // turn the line round and request the register
            st_next.sd_oe = 1'b0;
            st_next.rw = 1'b1;
            st_next.rx = 1'b1;
            st_next.bit_idx = 5'h00;
            st_next.ph = srp_pkg::HP_TURN;
          end else begin
            st_next.sel_n = 1'b1;
            st_next.sd_oe = 1'b0;
            st_next.rw = 1'b0;
            st_next.ph = srp_pkg::HP_FIN;
          end
        end
      end
      srp_pkg::HP_TURN: begin
        // device needs a few cycles to drive the first bit
        if (half_done) begin
          st_next.ph = srp_pkg::HP_LOW;
        end
      end
      srp_pkg::HP_FIN: begin
        // recycle gap with select high
        if (half_done) begin
          st_next.done = 1'b1;
          st_next.ph = srp_pkg::HP_IDLE;
        end
      end
      default: begin
        st_next.ph = srp_pkg::HP_IDLE;
      end
    endcase

    // register reads; set of done wins over its clear
    if (bus_rd) begin
      unique case (bus_addr)
        `SRP_H_STAT: begin
          st_next.bus_rdata[`SRP_STAT_BUSY] =
            st_reg.ph != srp_pkg::HP_IDLE;
          st_next.bus_rdata[`SRP_STAT_DONE] = st_reg.done;
          if (!(st_reg.ph == srp_pkg::HP_FIN && half_done)) begin
            st_next.done = 1'b0;
          end
        end
        `SRP_H_RDATA: begin
          st_next.bus_rdata[11:0] = st_reg.rdata;
        end
        default: begin
          st_next.bus_rdata = 32'h00000000;
        end
      endcase
    end
  end

  // single state register; select idles high
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
      st_reg.sel_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.port_select_n = st_reg.sel_n;
  assign link.rd_wr = st_reg.rw;
  assign link.serial_clk = st_reg.sclk;
  assign link.host_sdio_out = st_reg.sd_out;
  assign link.host_sdio_oe = st_reg.sd_oe;
  assign bus_rdata = st_reg.bus_rdata;
endmodule

/* core/srp_link_if.sv */
// the three-wire link plus the shared data line
// assumes each end drives only its own enable and data
interface srp_link_if;
  logic port_select_n; // frame select, low active
  logic rd_wr; // high: read, low: write
  logic serial_clk; // made by the host
  logic host_sdio_out;
  logic host_sdio_oe;
  logic dev_sdio_out;
  logic dev_sdio_oe;
  logic sdio; // resolved level of the data line

  // device wins if both drive; idle line pulled high
  assign sdio = dev_sdio_oe ? dev_sdio_out :
                (host_sdio_oe ? host_sdio_out : 1'b1);

  modport dev (
    input port_select_n,
    input rd_wr,
    input serial_clk,
    input sdio,
    output dev_sdio_out,
    output dev_sdio_oe
  );

  modport host (
    output port_select_n,
    output rd_wr,
    output serial_clk,
    output host_sdio_out,
    output host_sdio_oe,
    input sdio
  );
endinterface

/* core/srp_map.svh */
// constants for the serial register port and its power-on reset
// assumes a 10 MHz core clock on both ends of the link
`ifndef SRP_MAP_SVH
`define SRP_MAP_SVH

// frame layout
`define SRP_ADDR_BITS 5'h04
`define SRP_LAST_BIT 5'h0F
`define SRP_FRAME_BITS 5'h10
`define SRP_NUM_WREGS 7
`define SRP_FINE_CNT_IDX 3'h6
`define SRP_FINE_ERR_ADDR 4'h7
`define SRP_REG_RESET 12'h000

// timing
`define SRP_CLK_NS 100
`define SRP_CLK_MHZ 10
`define SRP_RST_DLY_US 1000
`define SRP_RST_DLY_CYC (`SRP_RST_DLY_US * `SRP_CLK_MHZ)
`define SRP_BRAKE_DELAY_CAPACITOR_US 500
`define SRP_BRAKE_DELAY_CAPACITOR_CYC (`SRP_BRAKE_DELAY_CAPACITOR_US * `SRP_CLK_MHZ)
`define SRP_HALF_NS 400
`define SRP_HALF_CYC (`SRP_HALF_NS / `SRP_CLK_NS)

// host command port map
`define SRP_H_CMD 8'h00
`define SRP_H_STAT 8'h04
`define SRP_H_RDATA 8'h08
`define SRP_CMD_READ 16
`define SRP_CMD_RBACK 17
`define SRP_STAT_BUSY 0
`define SRP_STAT_DONE 1

`endif

/* core/srp_pkg.sv */
// types shared by both ends of the serial register port
// assumes srp_map.svh is on the include path
package srp_pkg;

  // power monitor states
  typedef enum logic [1:0] {
    PWR_RESET = 2'b00,
    PWR_RUN = 2'b01,
    PWR_PARK = 2'b10,
    PWR_BRAKE = 2'b11
  } srp_pwr_e;

  // host engine phases
  typedef enum logic [2:0] {
    HP_IDLE = 3'b000,
    HP_SETUP = 3'b001,
    HP_LOW = 3'b010,
    HP_HIGH = 3'b011,
    HP_TURN = 3'b100,
    HP_FIN = 3'b101
  } srp_hph_e;

  // whole device state
  typedef struct packed {
    srp_pwr_e pwr;
    logic [15:0] dly_cnt;
    logic por_n;
    logic drv_en;
    logic park_en;
    logic brake_en;
    logic sclk_d;
    logic rw_d;
    logic rot_d;
    logic [4:0] bit_cnt;
    logic [3:0] addr;
    logic [11:0] data_in;
    logic [11:0] shift;
    logic sdio_out;
    logic sdio_oe;
    logic [6:0][11:0] regs;
    logic [11:0] period;
    logic [11:0] fine_err;
  } srp_dev_s;

  // whole host state
  typedef struct packed {
    srp_hph_e ph;
    logic [2:0] tmr;
    logic [4:0] bit_idx;
    logic is_read;
    logic rx;
    logic [15:0] frame;
    logic sel_n;
    logic rw;
    logic sclk;
    logic sd_out;
    logic sd_oe;
    logic [11:0] rdata;
    logic done;
    logic [31:0] bus_rdata;
  } srp_host_s;

endpackage

/* core/srp_sync.sv */
// two-flop synchroniser for a group of unrelated levels
// assumes each bit is a slow level; no bus coherence
module srp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg; // first stage, read only by the second
  logic [W-1:0] sync_reg; // second stage

  // one pair of flops per bit
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        meta_reg[i] <= RST_VAL[i];
        sync_reg[i] <= RST_VAL[i];
      end else begin
        meta_reg[i] <= async_in[i];
        sync_reg[i] <= meta_reg[i];
      end
    end
  end

  assign sync_out = sync_reg;
endmodule

/* tb/srp_link_sva.sv */
// checker for the serial link joining host and device ends
// assumes both ends share core_clk and link pins are sampled raw
module srp_link_sva (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic port_select_n,
  input wire logic rd_wr,
  input wire logic serial_clk,
  input wire logic host_sdio_out,
  input wire logic host_sdio_oe,
  input wire logic dev_sdio_out,
  input wire logic dev_sdio_oe,
  input wire logic sdio
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sclk_d; // serial clock one cycle back
  logic sclk_rise; // rise seen this cycle
  logic [4:0] frm_rises; // rises in the open frame
  logic [4:0] out_rises; // rises while the device drives
  logic [3:0] since_rise; // saturating age of the last rise
  assign sclk_rise = serial_clk && !sclk_d;

  // helper counters; saturate so a stuck clock cannot wrap to a pass
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_d <= 1'b0;
      frm_rises <= 5'h00;
      out_rises <= 5'h00;
      since_rise <= 4'hF;
    end else begin
      sclk_d <= serial_clk;
      if (port_select_n) begin // frame closed
        frm_rises <= 5'h00;
      end else if (sclk_rise && frm_rises != 5'h1F) begin
        frm_rises <= frm_rises + 5'h01;
      end
      if (!dev_sdio_oe) begin // device silent
        out_rises <= 5'h00;
      end else if (sclk_rise && out_rises != 5'h1F) begin
        out_rises <= out_rises + 5'h01;
      end
      if (sclk_rise) begin
        since_rise <= 4'h0;
      end else if (since_rise != 4'hF) begin
        since_rise <= since_rise + 4'h1;
      end
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  chk_write_float: assert property (
    (!port_select_n && !rd_wr) [*4] |-> !dev_sdio_oe)
    else $error("device drives data during a write");
  chk_desel_float: assert property (
    port_select_n [*4] |-> !dev_sdio_oe)
    else $error("device drives data while deselected");
  chk_read_drive: assert property (
    (!port_select_n && rd_wr) [*4] |-> dev_sdio_oe)
    else $error("device silent during a read");
  chk_no_clash: assert property (
    !(host_sdio_oe && dev_sdio_oe))
    else $error("both ends drive the data line");
  chk_frame_len: assert property (
    $rose(port_select_n) |-> frm_rises == 5'h10)
    else $error("frame closed without sixteen clocks");
  chk_rw_steady: assert property (
    $changed(rd_wr) |-> !serial_clk)
    else $error("direction changed while serial clock high");
  chk_shift_edge: assert property (
    dev_sdio_oe && $past(dev_sdio_oe) && $changed(dev_sdio_out)
    |-> since_rise <= 4'h5)
    else $error("read data moved away from a clock rise");
  chk_zero_fill: assert property (
    dev_sdio_oe && out_rises >= 5'h0C && since_rise >= 4'h5
    |-> !dev_sdio_out)
    else $error("nonzero bit after the register was shifted out");

  cover property (!port_select_n && !rd_wr && frm_rises == 5'h10);
  cover property (dev_sdio_oe && out_rises == 5'h0C);
  cover property ($rose(port_select_n) && rd_wr);
  cover property (dev_sdio_oe && sdio);
endmodule

/* tb/srp_tb.sv */
// bench joining host and device ends over the link interface
// assumes srp_map.svh on the include path; host makes the link clock
`include "srp_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RST_CYC = 20; // shortened reset delay
  localparam int BRK_CYC = 10; // shortened brake delay
  logic core_clk;
  logic rst_b;
  logic sense_a;
  logic sense_b;
  logic rot_pulse; // two rotation marks 100 cycles apart for the fine error check
  logic [6:0][11:0] cfg_words;
  logic por_n;
  logic drv_en;
  logic park_en;
  logic brake_en;
  logic [7:0] bus_addr;
  logic [31:0] bus_wdata;
  logic bus_wr;
  logic bus_rd;
  logic [31:0] bus_rdata;
  logic bus_chk; // this read carries a note
  logic chk_d; // noted read answers now
  logic [31:0] rdv; // last read value
  logic [83:0] exp_q[$]; // expected read data, oldest first
  logic [6:0][11:0] exp_cfg; // model of the written registers
  logic [11:0] w;
  int fail_count;
  int n_compared;
  int n;
  int seed;

  srp_link_if link_if ();
  srp_device #(.RST_DLY_CYC(RST_CYC), .BRAKE_DELAY_CAPACITOR_CYC(BRK_CYC))
    srp_device_inst (.core_clk(core_clk), .rst_b(rst_b), .link(link_if),
    .supply_sense_a(sense_a), .supply_sense_b(sense_b),
    .rot_pulse(rot_pulse), .cfg_words(cfg_words), .por_n(por_n),
    .drv_en(drv_en), .park_en(park_en), .brake_en(brake_en));
  srp_host srp_host_inst (.core_clk(core_clk), .rst_b(rst_b),
    .link(link_if), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
  srp_link_sva srp_link_sva_inst (.core_clk(core_clk), .rst_b(rst_b),
    .port_select_n(link_if.port_select_n), .rd_wr(link_if.rd_wr),
    .serial_clk(link_if.serial_clk),
    .host_sdio_out(link_if.host_sdio_out),
    .host_sdio_oe(link_if.host_sdio_oe),
    .dev_sdio_out(link_if.dev_sdio_out),
    .dev_sdio_oe(link_if.dev_sdio_oe), .sdio(link_if.sdio));

  // 10 MHz core clock
  always #50 core_clk = ~core_clk;

  task automatic check(input string what, input logic [83:0] seen,
                       input logic [83:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("mismatches %0d compared %0d", fail_count, n_compared);
    if (fail_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one-cycle write strobe
  task automatic bus_wr_cyc(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge core_clk);
    bus_wr <= 1'b0;
  endtask

  // one-cycle read strobe; data taken once the answer has landed
  task automatic bus_rd_cyc(input logic [7:0] a, input logic chk,
                            input logic [83:0] exp);
    if (chk) exp_q.push_back(exp);
    @(posedge core_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    bus_chk <= chk;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    bus_chk <= 1'b0;
    #1 rdv = bus_rdata;
  endtask

  // issue a frame command and poll done under a bound
  task automatic cmd(input logic [31:0] d);
    bus_wr_cyc(`SRP_H_CMD, d);
    for (int k = 0; k < 300; k++) begin
      bus_rd_cyc(`SRP_H_STAT, 1'b0, '0);
      if (rdv[`SRP_STAT_DONE] === 1'b1) return;
    end
    fail_count++;
    $display("frame never finished");
    stop_test();
  endtask

  // read one device register and note the value expected
  task automatic rd_reg(input logic [31:0] d, input logic [11:0] exp);
    cmd(d);
    bus_rd_cyc(`SRP_H_RDATA, 1'b1, {72'h0, exp});
  endtask

  // count cycles until por_n releases
  task automatic por_wait();
    n = 0;
    while (por_n !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
  endtask

  // answer watcher: compares each noted read in its data cycle
  always @(posedge core_clk) begin
    chk_d <= bus_rd && bus_chk;
    if (chk_d && exp_q.size() > 0) begin
      check("read data", bus_rdata, exp_q.pop_front());
    end
  end

  // hang guard, far beyond the few thousand cycles needed
  initial begin
    #2000000;
    fail_count++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    sense_a = 1'b1;
    sense_b = 1'b1;
    rot_pulse = 1'b0;
    bus_addr = 8'h00;
    bus_wdata = 32'h0000_0000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_chk = 1'b0;
    fail_count = 0;
    n_compared = 0;
    exp_cfg = '0;
    seed = $urandom(4639);
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    // boot: delay, defaults, error count at zero
    por_wait();
    check("boot delay", n >= RST_CYC && n <= RST_CYC + 8, 1'b1);
    check("drivers on", drv_en, 1'b1);
    check("defaults", cfg_words, exp_cfg);
    rd_reg(32'h0001_0007, 12'h000);
    // every writable register with random data
    for (int i = 0; i < 7; i++) begin
      w = 12'($urandom);
      exp_cfg[i] = w;
      cmd({16'h0000, w, 4'(i)});
    end
    check("written words", cfg_words, exp_cfg);
    // unreadable address shifts out the last written word
    rd_reg(32'h0001_0003, exp_cfg[6]);
    w = 12'($urandom);
    exp_cfg[2] = w;
    cmd({16'h0000, w, 4'h2});
    rd_reg(32'h0002_0000, w);
    // write to the read-only place is dropped
    cmd({16'h0000, 12'hA5C, 4'h7});
    check("read-only drop", cfg_words, exp_cfg);
    // second command while busy is refused
    exp_cfg[1] = 12'h3C5;
    bus_wr_cyc(`SRP_H_CMD, {16'h0000, 12'h3C5, 4'h1});
    cmd({16'h0000, 12'hFFF, 4'h0});
    check("busy refusal", cfg_words, exp_cfg);
    bus_rd_cyc(8'h0C, 1'b1, '0);
    // fine error from two rotation marks 100 cycles apart
    w = 12'($urandom) & 12'h7FF;
    exp_cfg[6] = w;
    cmd({16'h0000, w, 4'h6});
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      rot_pulse <= 1'b1;
      repeat (2) @(posedge core_clk);
      rot_pulse <= 1'b0;
      repeat (97) @(posedge core_clk);
    end
    rd_reg(32'h0001_0007, w - 12'h064);
    // low supply on each sense input in turn
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      if (i == 0) sense_a <= 1'b0;
      else sense_b <= 1'b0;
      n = 0;
      while (por_n !== 1'b0 && n < 20) begin
        @(posedge core_clk);
        n++;
      end
      check("low supply seen", n <= 5, 1'b1);
      @(posedge core_clk);
      check("park state", {park_en, drv_en, brake_en}, 3'b100);
      check("regs cleared", cfg_words, '0);
      n = 0;
      while (brake_en !== 1'b1 && n < 100) begin
        @(posedge core_clk);
        n++;
      end
      check("brake delay", n >= BRK_CYC - 3 && n <= BRK_CYC + 3, 1'b1);
      sense_a <= 1'b1;
      sense_b <= 1'b1;
      por_wait();
      check("restart delay", n >= RST_CYC && n <= RST_CYC + 8, 1'b1);
      check("drivers back", drv_en, 1'b1);
    end
    rd_reg(32'h0001_0007, 12'h000);
    repeat (4) @(posedge core_clk);
    stop_test();
  end
endmodule
